/* File: design/pup_consts.svh */
// Purpose: constants for the port pull-up block
// Assumes: eight-bit port, mode codes as in the device mode pins
// Notes: definitions only
`ifndef PUP_CONSTS_SVH
`define PUP_CONSTS_SVH
`define PUP_WIDTH        8
`define PUP_DIR_RESET    8'h00
`define PUP_LATCH_RESET  8'h00
`define PUP_MODE_W       3
`define PUP_MODE_1       3'h1
`define PUP_MODE_2       3'h2
`define PUP_MODE_3       3'h3
`define PUP_MODE_4       3'h4
`define PUP_MODE_SINGLE  3'h7
`endif

/* File: design/pup_pkg.sv */
// Purpose: types for the port pull-up block
// Assumes: constants header included
// Notes: none
`include "pup_consts.svh"
package pup_pkg;
  typedef logic [`PUP_WIDTH-1:0] pup_byte_t;
  typedef enum logic [1:0] {
    PUP_PUP_OFF  = 2'h0,
    PUP_PUP_PROG = 2'h1
  } pup_pmode_e;
  typedef struct packed {
    logic      wrEn;
    pup_byte_t wrData;
  } pup_wr_s;
endpackage : pup_pkg

/* File: design/pup_sync.sv */
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: pins are asynchronous to ref_clk
// Notes: stage one is read only by stage two
`timescale 1ns/100ps
`include "pup_consts.svh"
module pup_sync (
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire pup_pkg::pup_byte_t pinIn,
  output pup_pkg::pup_byte_t     pinLevel
);
  pup_pkg::pup_byte_t s1_q;
  pup_pkg::pup_byte_t s2_q;
  pup_pkg::pup_byte_t s3_q;
  pup_pkg::pup_byte_t lvl_q;

  always_ff @(posedge ref_clk) begin
    s1_q <= pinIn;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  genvar i;
  generate
    for (i = 0; i < `PUP_WIDTH; i++) begin : g_bit
      // a change counts only once stages two and three agree
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          lvl_q[i] <= 1'h0;
        end else if (s2_q[i] == s3_q[i]) begin
          lvl_q[i] <= s3_q[i];
        end
      end
    end
  endgenerate

  assign pinLevel = lvl_q;
endmodule : pup_sync

/* File: design/pup_port.sv */
// Purpose: eight-bit port with direction, output latch and programmable pull-ups
// Assumes: writes and reads are single-cycle strobes from the cpu side
// Notes: bit operations are done by the cpu as read-modify-write of the whole byte
`timescale 1ns/100ps
`include "pup_consts.svh"
module pup_port (
  input  wire logic                    ref_clk,
  input  wire logic                    srst,
  input  wire logic                    hwStandby,
  input  wire logic [`PUP_MODE_W-1:0]  opMode,
  input  wire pup_pkg::pup_wr_s        dirWr,
  input  wire pup_pkg::pup_wr_s        latchWr,
  input  wire logic                    latchRd,
  output pup_pkg::pup_byte_t           latchRdData,
  output logic                         latchRdValid,
  input  wire pup_pkg::pup_byte_t      pinIn,
  output pup_pkg::pup_byte_t           pinOut,
  output pup_pkg::pup_byte_t           pinOe,
  output pup_pkg::pup_byte_t           pullUpEn,
  output pup_pkg::pup_byte_t           addrOe
);
  pup_pkg::pup_byte_t dir_q;
  pup_pkg::pup_byte_t latch_q;
  pup_pkg::pup_byte_t rdData_q;
  logic               rdValid_q;
  pup_pkg::pup_byte_t pinLevel;
  pup_pkg::pup_pmode_e pmode;
  logic               clrAll;
  logic               modeFixed;
  logic               modeRom;

  assign clrAll    = srst | hwStandby;
  assign modeFixed = (opMode == `PUP_MODE_1) || (opMode == `PUP_MODE_3);
  assign modeRom   = (opMode == `PUP_MODE_2) || (opMode == `PUP_MODE_4);

  pup_sync u_sync (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .pinIn    (pinIn),
    .pinLevel (pinLevel)
  );

  // direction register; fixed modes hold it at all ones for address output
  always_ff @(posedge ref_clk) begin
    if (clrAll) begin
      dir_q <= `PUP_DIR_RESET;
    end else if (modeFixed) begin
      dir_q <= 8'hFF;
    end else if (dirWr.wrEn) begin
      dir_q <= dirWr.wrData;
    end
  end

  // whole byte loads, so input-pin latch bits (and their pull-ups) change too
  always_ff @(posedge ref_clk) begin
    if (clrAll) begin
      latch_q <= `PUP_LATCH_RESET;
    end else if (latchWr.wrEn) begin
      latch_q <= latchWr.wrData;
    end
  end

  // read answer one cycle after the strobe; a bit-op write follows this read
  always_ff @(posedge ref_clk) begin
    if (clrAll) begin
      rdData_q  <= 8'h00;
      rdValid_q <= 1'h0;
    end else begin
      rdValid_q <= latchRd;
      if (latchRd) begin
        rdData_q <= (dir_q & latch_q) | (~dir_q & pinLevel);
      end
    end
  end

  assign latchRdData  = rdData_q;
  assign latchRdValid = rdValid_q;

  always_comb begin
    if (clrAll || modeFixed) begin
      pmode = pup_pkg::PUP_PUP_OFF;
    end else begin
      pmode = pup_pkg::PUP_PUP_PROG;
    end
  end

  // no register stage: the enable tracks the registers directly
  always_comb begin
    case (pmode)
      pup_pkg::PUP_PUP_PROG: pullUpEn = ~dir_q & latch_q;
      pup_pkg::PUP_PUP_OFF:  pullUpEn = 8'h00;
      default:               pullUpEn = 8'h00;
    endcase
  end

  // single-chip drives the latch; expanded modes hand output pins to the address bus
  always_comb begin
    if (opMode == `PUP_MODE_SINGLE) begin
      pinOe  = dir_q;
      pinOut = latch_q;
      addrOe = 8'h00;
    end else if (modeFixed || modeRom) begin
      pinOe  = 8'h00;
      pinOut = 8'h00;
      addrOe = dir_q;
    end else begin
      pinOe  = 8'h00;
      pinOut = 8'h00;
      addrOe = 8'h00;
    end
  end

  property p_pullOffStandby;
    @(posedge ref_clk) hwStandby |-> (pullUpEn == 8'h00);
  endproperty
  a_pullOffStandby: assert property (p_pullOffStandby)
    else $error("pull-up on during standby");

  property p_pullOffFixed;
    @(posedge ref_clk) disable iff (srst) modeFixed |-> (pullUpEn == 8'h00);
  endproperty
  a_pullOffFixed: assert property (p_pullOffFixed)
    else $error("pull-up on in mode 1 or 3");

  property p_pullRule;
    @(posedge ref_clk) disable iff (srst)
      (modeRom || opMode == `PUP_MODE_SINGLE) && !hwStandby |-> pullUpEn == (~dir_q & latch_q);
  endproperty
  a_pullRule: assert property (p_pullRule)
    else $error("pull-up does not follow direction and latch");

  sequence s_wrTaken;
    latchWr.wrEn && !hwStandby;
  endsequence
  property p_wrLoads;
    @(posedge ref_clk) disable iff (srst)
      s_wrTaken |=> latch_q == $past(latchWr.wrData);
  endproperty
  a_wrLoads: assert property (p_wrLoads)
    else $error("latch not loaded by write");

  // a data-only write in a programmable mode, still programmable one cycle later
  sequence s_latchOnlyWr;
    latchWr.wrEn && !dirWr.wrEn && !modeFixed ##1 !modeFixed;
  endsequence
  property p_wrPull;
    @(posedge ref_clk) disable iff (srst || hwStandby)
      s_latchOnlyWr |-> pullUpEn == (~$past(dir_q) & $past(latchWr.wrData));
  endproperty
  a_wrPull: assert property (p_wrPull)
    else $error("pull-up not updated after write");

  property p_readMux;
    @(posedge ref_clk) disable iff (srst || hwStandby)
      latchRd |=> latchRdValid && latchRdData ==
        (($past(dir_q) & $past(latch_q)) | (~$past(dir_q) & $past(pinLevel)));
  endproperty
  a_readMux: assert property (p_readMux)
    else $error("read data mixes pin and latch wrongly");

  property p_clearRegs;
    @(posedge ref_clk) (srst || hwStandby) |=> dir_q == 8'h00 && latch_q == 8'h00;
  endproperty
  a_clearRegs: assert property (p_clearRegs)
    else $error("registers not cleared");

  property p_singleDrive;
    @(posedge ref_clk) disable iff (srst)
      opMode == `PUP_MODE_SINGLE |-> pinOe == dir_q && pinOut == latch_q;
  endproperty
  a_singleDrive: assert property (p_singleDrive)
    else $error("single-chip pin drive wrong");

  // reset alone must kill the pull-ups too, not only standby
  property p_pullOffReset;
    @(posedge ref_clk) srst |-> (pullUpEn == 8'h00);
  endproperty
  a_pullOffReset: assert property (p_pullOffReset)
    else $error("pull-up on during reset");

  sequence s_fixedHeld;
    modeFixed ##1 modeFixed;
  endsequence
  property p_fixedDir;
    @(posedge ref_clk) disable iff (srst || hwStandby)
      s_fixedHeld |-> dir_q == 8'hFF && addrOe == 8'hFF;
  endproperty
  a_fixedDir: assert property (p_fixedDir)
    else $error("direction not forced in mode 1 or 3");

  property p_dirWrite;
    @(posedge ref_clk) disable iff (srst || hwStandby)
      dirWr.wrEn && !modeFixed |=> dir_q == $past(dirWr.wrData);
  endproperty
  a_dirWrite: assert property (p_dirWrite)
    else $error("direction write not taken");

  property p_rdHold;
    @(posedge ref_clk) disable iff (srst || hwStandby)
      !latchRd |=> !latchRdValid && $stable(latchRdData);
  endproperty
  a_rdHold: assert property (p_rdHold)
    else $error("read answer changed without a read");

  property p_expandedNoDrive;
    @(posedge ref_clk) (modeFixed || modeRom) |-> pinOe == 8'h00 && addrOe == dir_q;
  endproperty
  a_expandedNoDrive: assert property (p_expandedNoDrive)
    else $error("latch drives a pin in an expanded mode");

  // spare mode codes keep programmable pull-ups but drive nothing
  property p_spareNoDrive;
    @(posedge ref_clk) !modeFixed && !modeRom && opMode != `PUP_MODE_SINGLE
      |-> pinOe == 8'h00 && pinOut == 8'h00 && addrOe == 8'h00;
  endproperty
  a_spareNoDrive: assert property (p_spareNoDrive)
    else $error("pin driven in a spare mode");
endmodule : pup_port

/* File: tb/pup_board.sv */
// Purpose: board circuitry on the eight port pins
// Assumes: the board drives only the pins set in extDrv, the rest float
// Notes: a strong board driver overrides the weak pull-up
`timescale 1ns/100ps
module pup_board (
  input  wire pup_pkg::pup_byte_t pinOut,
  input  wire pup_pkg::pup_byte_t pinOe,
  input  wire pup_pkg::pup_byte_t pullUpEn,
  input  wire pup_pkg::pup_byte_t extVal,
  input  wire pup_pkg::pup_byte_t extDrv,
  output pup_pkg::pup_byte_t      pinIn
);
  // a floating pin rises through its pull-up, otherwise leaks low
  assign pinIn = (pinOe & pinOut)
               | (~pinOe & ((extDrv & extVal) | (~extDrv & pullUpEn)));
endmodule : pup_board

/* File: tb/pup_port_tb_top.sv */
// Purpose: self-checking bench for the port pull-up block
// Assumes: inputs change at the falling edge of ref_clk
// Notes: random bytes from a fixed seed plus the read-modify-write corner
`timescale 1ns/100ps
`include "pup_consts.svh"
module pup_port_tb_top;
  // the run needs a few hundred cycles; the ceiling leaves ample margin
  localparam int MaxCycles = 2000;
  logic                   ref_clk;
  logic                   srst;
  logic                   hwStandby;
  logic [`PUP_MODE_W-1:0] opMode;
  pup_pkg::pup_wr_s       dirWr;
  pup_pkg::pup_wr_s       latchWr;
  logic                   latchRd;
  logic                   latchRdValid;
  pup_pkg::pup_byte_t     latchRdData, pinIn, pinOut, pinOe, pullUpEn, addrOe;
  pup_pkg::pup_byte_t     extVal, extDrv, d, l, r, shadow;
  int                     numErrors, nChecks, cyc;
  logic [`PUP_MODE_W-1:0] modes [5] = '{`PUP_MODE_1, `PUP_MODE_2, `PUP_MODE_3,
                                        `PUP_MODE_4, `PUP_MODE_SINGLE};
  pup_port DUT (.ref_clk(ref_clk), .srst(srst), .hwStandby(hwStandby), .opMode(opMode),
    .dirWr(dirWr), .latchWr(latchWr), .latchRd(latchRd), .latchRdData(latchRdData),
    .latchRdValid(latchRdValid), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .pullUpEn(pullUpEn), .addrOe(addrOe));
  pup_board board (.pinOut(pinOut), .pinOe(pinOe), .pullUpEn(pullUpEn), .extVal(extVal),
    .extDrv(extDrv), .pinIn(pinIn));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic pup_pkg::pup_byte_t pupExp(input logic [2:0] m, pup_pkg::pup_byte_t dd, ll);
    return (m == `PUP_MODE_1 || m == `PUP_MODE_3) ? 8'h00 : (~dd & ll);
  endfunction : pupExp
  // address output: every pin in modes 1/3, per direction bit in modes 2/4
  function automatic pup_pkg::pup_byte_t addrExp(input logic [2:0] m, pup_pkg::pup_byte_t dd);
    if (m == `PUP_MODE_1 || m == `PUP_MODE_3) begin
      return 8'hFF;
    end
    return (m == `PUP_MODE_2 || m == `PUP_MODE_4) ? dd : 8'h00;
  endfunction : addrExp
  // single-chip read: latch for outputs, board level or own pull-up for inputs
  function automatic pup_pkg::pup_byte_t readExp(input pup_pkg::pup_byte_t dd, ll, ev, ed);
    pup_pkg::pup_byte_t lvl;
    lvl = (ed & ev) | (~ed & ~dd & ll);
    return (dd & ll) | (~dd & lvl);
  endfunction : readExp
  task automatic chk(input pup_pkg::pup_byte_t e, g);
    nChecks++;
    if (g !== e) begin
      numErrors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic chkFlag(input logic e, g);
    nChecks++;
    if (g !== e) begin
      numErrors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chkFlag
  task automatic wr(input pup_pkg::pup_byte_t dd, ll);
    @(negedge ref_clk);
    dirWr = '{1'b1, dd};
    latchWr = '{1'b1, ll};
    @(negedge ref_clk);
    dirWr.wrEn = 1'b0;
    latchWr.wrEn = 1'b0;
  endtask : wr
  task automatic wrL(input pup_pkg::pup_byte_t ll);
    @(negedge ref_clk);
    latchWr = '{1'b1, ll};
    @(negedge ref_clk);
    latchWr.wrEn = 1'b0;
  endtask : wrL
  // pins pass a three-stage synchroniser, so let them settle before reading
  task automatic rd(output pup_pkg::pup_byte_t q);
    repeat (6) @(negedge ref_clk);
    latchRd = 1'b1;
    @(negedge ref_clk);
    latchRd = 1'b0;
    chkFlag(1'b1, latchRdValid);
    q = latchRdData;
    @(negedge ref_clk);
    chkFlag(1'b0, latchRdValid);
    chk(q, latchRdData);
  endtask : rd
  task automatic completeRun;
    $display("checks=%0d errors=%0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : completeRun
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == MaxCycles) begin
      numErrors++;
      completeRun();
    end
  end
  initial begin
    srst = 1'b1;
    hwStandby = 1'b0;
    opMode = `PUP_MODE_SINGLE;
    latchRd = 1'b0;
    dirWr = '0;
    latchWr = '0;
    extVal = 8'h5A;
    extDrv = 8'hFF;
    void'($urandom(32'hCA2C13AC));
    repeat (4) @(negedge ref_clk);
    chk(8'h00, pullUpEn);
    srst = 1'b0;
    chk(8'h00, pinOe);
    rd(r);
    chk(8'h5A, r);
    $display("reset test done");
    foreach (modes[i]) begin
      opMode = modes[i];
      repeat (12) begin
        {d, l, extVal, extDrv} = $urandom;
        wr(d, l);
        chk(pupExp(opMode, d, l), pullUpEn);
        chk(addrExp(opMode, d), addrOe);
        chk((opMode == `PUP_MODE_SINGLE) ? d : 8'h00, pinOe);
        chk((opMode == `PUP_MODE_SINGLE) ? l : 8'h00, pinOut);
        if (opMode == `PUP_MODE_SINGLE) begin
          rd(r);
          chk(readExp(d, l, extVal, extDrv), r);
        end
      end
    end
    $display("mode test done");
    opMode = `PUP_MODE_SINGLE;
    extVal = 8'h40;
    extDrv = 8'hFF;
    wr(8'h3F, 8'h80);
    chk(8'h80, pullUpEn);
    rd(r);
    chk(8'h40, r);
    wrL(r | 8'h01);
    chk(8'h40, pullUpEn);
    chk(8'h01, pinOut & 8'h3F);
    shadow = 8'h80;
    wrL(shadow);
    shadow = shadow | 8'h01;
    wrL(shadow);
    chk(8'h80, pullUpEn);
    chk(8'h81, pinOut);
    $display("bit op test done");
    @(negedge ref_clk);
    hwStandby = 1'b1;
    #1 chk(8'h00, pullUpEn);
    @(negedge ref_clk);
    hwStandby = 1'b0;
    chk(8'h00, pinOe);
    chk(8'h00, pinOut);
    chk(8'h00, pullUpEn);
    wr(8'h00, 8'hFF);
    chk(8'hFF, pullUpEn);
    srst = 1'b1;
    #1 chk(8'h00, pullUpEn);
    @(negedge ref_clk);
    srst = 1'b0;
    chk(8'h00, pullUpEn);
    extVal = 8'hA5;
    rd(r);
    chk(8'hA5, r);
    $display("standby test done");
    completeRun();
  end
endmodule : pup_port_tb_top
